// ===== rtl/tpsr_pair_route.sv
// Start routing and register slave for one even/odd timer channel pair
//
// Behaviour
// RULE1 - In mode 5 all channels whose start bit is written with one start in the same cycle.
// RULE2 - Writing one to a start bit raises that channel's clock, trigger and wave inputs.
// RULE3 - In modes 5 and 6 the out pins carry the channel waveforms and the in pins are ignored.
// RULE4 - Software sets each channel's trigger edge select to rising edge for these modes.
// RULE5 - In mode 6 a start write to the even bit raises the even channel's inputs.
// RULE6 - In mode 6 the odd channel starts on the even waveform's rise and stops on its fall.
// RULE7 - In mode 6 the even waveform drives all four odd channel inputs, stop included.
// RULE8 - The odd channel stops whenever its stop trigger input falls.
// RULE9 - In modes 6 and 7 the even waveform is exported as the chained output.
// RULE10 - In mode 7 the even waveform drives the odd clock, trigger and wave inputs.
// RULE11 - In mode 7 the even in pin feeds the even channel and the odd in pin is ignored.
// RULE12 - In mode 7 the odd channel starts on the even waveform's rise, as in mode 4.
// RULE13 - A four-bit mode field selects 5, 6 or 7; codes above 8 are refused.
// RULE14 - In start/stop routing the odd channel runs while the even waveform is high.
// RULE15 - Start bits self-clear so each write of one gives exactly one rising edge.
//
// The register offsets and the strobed register port were left to the implementer.
module tpsr_pair_route (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register bus
  input wire tpsr_pkg::tpsr_bus_req_t bus_req,
  output logic [tpsr_pkg::DATA_W-1:0] bus_rdata,
  // Pins
  input wire logic timer_in_pin_even,
  input wire logic timer_in_pin_odd,
  output logic timer_out_pin_even,
  output logic timer_out_pin_odd,
  // Channel cores
  input wire logic channel_waveform_out_even,
  input wire logic channel_waveform_out_odd,
  output tpsr_pkg::tpsr_chan_in_t chan_even,
  output tpsr_pkg::tpsr_chan_in_t chan_odd,
  // Neighbouring pairs
  input wire logic chained_in,
  output logic chained_out
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------

  // One source fans out to the clock, trigger and wave inputs of a channel core; stop has its own source
  function automatic tpsr_pkg::tpsr_chan_in_t fan(input logic src, input logic stop);
    tpsr_pkg::tpsr_chan_in_t r;
    r.external_clock_in = src;
    r.external_trigger_in = src;
    r.measured_wave_in = src;
    r.stop_trigger_in = stop;
    return r;
  endfunction

  // Codes above MODE_LAST_LEGAL (8) are prohibited
  function automatic logic mode_legal(input logic [3:0] code);
    return (code <= tpsr_pkg::MODE_LAST_LEGAL);
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [3:0] pair_mode_select;
  logic mode_rejected;
  logic [1:0] pin_sync;
  tpsr_pkg::tpsr_chan_in_t next_chan_even;
  tpsr_pkg::tpsr_chan_in_t next_chan_odd;
  logic [tpsr_pkg::DATA_W-1:0] next_rdata;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  tpsr_sync2 #(
    .WIDTH(tpsr_pkg::SYNC_STAGES)
  ) u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({timer_in_pin_odd, timer_in_pin_even}),
    .sync_out(pin_sync)
  );

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  wire hit_mode = bus_req.addr == tpsr_pkg::OFS_MODE;
  wire hit_start = bus_req.addr == tpsr_pkg::OFS_START;
  wire hit_status = bus_req.addr == tpsr_pkg::OFS_STATUS;
  wire [3:0] wr_mode_val = bus_req.wdata[tpsr_pkg::MODE_LSB +: 4];
  wire wr_mode = bus_req.wr && hit_mode;
  wire wr_mode_bad = wr_mode && !mode_legal(wr_mode_val);
  wire clr_reject = bus_req.wr && hit_status && bus_req.wdata[tpsr_pkg::ST_REJECT];

  // Start strikes are taken straight from the write, so they never linger
  wire start_even = bus_req.wr && hit_start &&
    bus_req.wdata[tpsr_pkg::START_EVEN_BIT]; // [RULE15]
  wire start_odd = bus_req.wr && hit_start &&
    bus_req.wdata[tpsr_pkg::START_ODD_BIT]; // [RULE15]

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  wire is_sw_sim = pair_mode_select == tpsr_pkg::MODE_SW_SIM; // [RULE13]
  wire is_sw_stst = pair_mode_select == tpsr_pkg::MODE_SW_STST; // [RULE13]
  wire is_tmr_start = pair_mode_select == tpsr_pkg::MODE_TMR_START; // [RULE13]
  wire even_exported = is_sw_stst || is_tmr_start;

  // ------------------------------------------------------------------
  // Mode register and reject flag
  // ------------------------------------------------------------------

  // Prohibited codes are dropped so the routing never sees them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pair_mode_select <= tpsr_pkg::MODE_RESET;
    end else if (wr_mode && !wr_mode_bad) begin
      pair_mode_select <= wr_mode_val; // [RULE13]
    end
  end

  // A refused write in the same cycle as a clear keeps the flag set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_rejected <= 1'b0;
    end else if (wr_mode_bad) begin
      mode_rejected <= 1'b1; // [RULE13]
    end else if (clr_reject) begin
      mode_rejected <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Channel input routing
  // ------------------------------------------------------------------

  // Even channel source by mode; other modes take the synchronised pin
  always_comb begin
    if (is_sw_sim || is_sw_stst) begin
      next_chan_even = fan(start_even, 1'b1); // [RULE2] [RULE5] [RULE3]
    end else begin
      next_chan_even = fan(pin_sync[0], 1'b1); // [RULE11]
    end
  end

  // Odd channel source; outside mode 6 the stop input idles high so no false fall
  always_comb begin
    if (is_sw_sim) begin
      next_chan_odd = fan(start_odd, 1'b1); // [RULE1] [RULE2] [RULE3]
    end else if (is_sw_stst) begin
      next_chan_odd = fan(channel_waveform_out_even,
        channel_waveform_out_even); // [RULE6] [RULE7] [RULE8] [RULE14]
    end else if (is_tmr_start) begin
      next_chan_odd = fan(channel_waveform_out_even, 1'b1); // [RULE10] [RULE12]
    end else begin
      next_chan_odd = fan(pin_sync[1], 1'b1);
    end
  end

  // All channel inputs share one register stage, so paired starts align
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chan_even <= '0;
      chan_odd <= '0;
    end else begin
      chan_even <= next_chan_even; // [RULE1]
      chan_odd <= next_chan_odd; // [RULE1]
    end
  end

  // ------------------------------------------------------------------
  // Pin outputs and chaining
  // ------------------------------------------------------------------

  // Waveforms take the same one-cycle stage as the odd channel feed
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      timer_out_pin_even <= 1'b0;
      timer_out_pin_odd <= 1'b0;
      chained_out <= 1'b0;
    end else begin
      timer_out_pin_even <= channel_waveform_out_even; // [RULE3]
      timer_out_pin_odd <= channel_waveform_out_odd; // [RULE3]
      chained_out <= even_exported ? channel_waveform_out_even : chained_in; // [RULE9]
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------

  // Unmapped addresses and the start register read as zero
  always_comb begin
    next_rdata = '0;
    if (bus_req.rd && hit_mode) begin
      next_rdata[tpsr_pkg::MODE_LSB +: 4] = pair_mode_select;
    end else if (bus_req.rd && hit_status) begin
      next_rdata[tpsr_pkg::ST_CHANNEL_WAVEFORM_OUT_EVEN] = channel_waveform_out_even;
      next_rdata[tpsr_pkg::ST_CHANNEL_WAVEFORM_OUT_ODD] = channel_waveform_out_odd;
      next_rdata[tpsr_pkg::ST_REJECT] = mode_rejected;
      next_rdata[tpsr_pkg::ST_PIN_EVEN] = pin_sync[0];
      next_rdata[tpsr_pkg::ST_PIN_ODD] = pin_sync[1];
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Mode as it stood one cycle ago; the routing stage lags the mode by that much
  logic [3:0] mode_prev;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_prev <= tpsr_pkg::MODE_RESET;
    end else begin
      mode_prev <= pair_mode_select;
    end
  end

  // Mode held over the last cycle, so one-stage checks are fair
  wire mode_held = pair_mode_select == mode_prev;

  AST_SIM_TOGETHER: assert property ( // [RULE1]
    (is_sw_sim && !wr_mode && start_even && start_odd)
      |=> chan_even.external_clock_in && chan_odd.external_clock_in)
    else $error("paired start not in the same cycle");

  AST_START_EDGE: assert property ( // [RULE2]
    (is_sw_sim && !wr_mode && start_odd) |=> $rose(chan_odd.external_trigger_in)
      || $past(start_odd, 2))
    else $error("start write gave no rising edge");

  AST_SW_PINS_IGNORED: assert property ( // [RULE3]
    (is_sw_sim && mode_held && chan_even.external_clock_in) |-> $past(start_even))
    else $error("even input rose without a start write");

  AST_PIN_WAVE: assert property ( // [RULE3]
    ##1 timer_out_pin_odd == $past(channel_waveform_out_odd))
    else $error("odd out pin does not follow waveform");

  AST_STST_EVEN_START: assert property ( // [RULE5]
    (is_sw_stst && !wr_mode && start_even)
      |=> chan_even.measured_wave_in ##1 (chan_even.measured_wave_in == $past(start_even)))
    else $error("even channel not started by software");

  AST_STST_ODD_GATE: assert property ( // [RULE6]
    (is_sw_stst && mode_held) |-> chan_odd.external_trigger_in
      == $past(channel_waveform_out_even))
    else $error("odd start does not follow even waveform");

  AST_STST_STOP: assert property ( // [RULE7]
    (is_sw_stst && mode_held) |-> chan_odd.stop_trigger_in == timer_out_pin_even)
    else $error("odd stop input not tied to even waveform");

  AST_STOP_FALL: assert property ( // [RULE8]
    (is_sw_stst && !wr_mode && $fell(channel_waveform_out_even))
      |=> $fell(chan_odd.stop_trigger_in))
    else $error("even fall did not stop odd channel");

  AST_CHAIN: assert property ( // [RULE9]
    (even_exported && mode_held) |-> chained_out == timer_out_pin_even)
    else $error("chained output not the even waveform");

  AST_TS_ODD: assert property ( // [RULE10]
    (is_tmr_start && mode_held) |-> chan_odd.external_clock_in == timer_out_pin_even
      && chan_odd.stop_trigger_in)
    else $error("odd inputs not from even waveform");

  AST_TS_EVEN_PIN: assert property ( // [RULE11]
    (is_tmr_start && mode_held) |-> chan_even.external_trigger_in == $past(pin_sync[0]))
    else $error("even input not from even pin");

  AST_TS_ODD_START: assert property ( // [RULE12]
    (is_tmr_start && mode_held && $rose(channel_waveform_out_even))
      |=> $rose(chan_odd.external_trigger_in))
    else $error("odd channel missed even rising edge");

  AST_MODE_REFUSED: assert property ( // [RULE13]
    wr_mode_bad |=> $stable(pair_mode_select) && mode_rejected)
    else $error("prohibited mode code accepted");

  AST_STST_RUN: assert property ( // [RULE14]
    (is_sw_stst && mode_held && timer_out_pin_even) |-> chan_odd.measured_wave_in)
    else $error("odd channel not running while even high");

  AST_SELF_CLEAR: assert property ( // [RULE15]
    (is_sw_sim && !wr_mode && start_even) ##1 !start_even |=> !chan_even.external_clock_in)
    else $error("start bit did not self-clear");

  // Further checks on start bits, pins, out pins, stop inputs and the mode register
  AST_SELF_CLEAR_ODD: assert property ( // [RULE15]
    (is_sw_sim && start_odd) ##1 !start_odd |=> !chan_odd.external_clock_in)
    else $error("odd start bit did not self-clear");

  AST_SIM_ODD_SW_ONLY: assert property ( // [RULE3]
    (is_sw_sim && mode_held && chan_odd.external_clock_in) |-> $past(start_odd))
    else $error("odd input rose without a start write");

  AST_STST_EVEN_SW_ONLY: assert property ( // [RULE3]
    (is_sw_stst && mode_held && chan_even.external_clock_in) |-> $past(start_even))
    else $error("even input rose without a start write in mode 6");

  AST_EVEN_PIN_WAVE: assert property ( // [RULE3]
    ##1 timer_out_pin_even == $past(channel_waveform_out_even))
    else $error("even out pin does not follow waveform");

  AST_SIM_NO_STOP: assert property ( // [RULE8]
    (is_sw_sim && mode_held) |-> chan_even.stop_trigger_in && chan_odd.stop_trigger_in)
    else $error("stop input low in simultaneous start mode");

  AST_STST_ODD_NO_SW: assert property ( // [RULE7]
    (is_sw_stst && start_odd && !channel_waveform_out_even) |=> !chan_odd.external_clock_in)
    else $error("odd start bit reached odd channel");

  AST_MODE_TAKEN: assert property ( // [RULE13]
    (wr_mode && !wr_mode_bad) |=> pair_mode_select == $past(wr_mode_val))
    else $error("legal mode code not stored");

  AST_MODE_LEGAL: assert property ( // [RULE13]
    mode_legal(pair_mode_select))
    else $error("prohibited mode code stored");

  AST_MODE_READBACK: assert property ( // [RULE13]
    (bus_req.rd && hit_mode) |=> bus_rdata[tpsr_pkg::MODE_LSB +: 4] == $past(pair_mode_select))
    else $error("mode field read back wrong");

  COV_SIM_BOTH: cover property (is_sw_sim && start_even && start_odd);
  COV_STST_RUN: cover property (is_sw_stst && $rose(chan_odd.external_trigger_in));
  COV_TS_PIN: cover property (is_tmr_start && $rose(chan_even.external_clock_in));
  COV_REJECT: cover property (wr_mode_bad);
  COV_STST_STOP: cover property (is_sw_stst && $fell(chan_odd.stop_trigger_in));

endmodule // tpsr_pair_route

// ===== rtl/tpsr_pkg.sv
// Shared constants and carriers for the timer pair start routing block
package tpsr_pkg;

  // ------------------------------------------------------------------
  // Register bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_START = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int START_EVEN_BIT = 0;
  localparam int START_ODD_BIT = 1;
  localparam int ST_CHANNEL_WAVEFORM_OUT_EVEN = 0;
  localparam int ST_CHANNEL_WAVEFORM_OUT_ODD = 1;
  localparam int ST_REJECT = 2;
  localparam int ST_PIN_EVEN = 3;
  localparam int ST_PIN_ODD = 4;

  // ------------------------------------------------------------------
  // Pair mode codes and reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] MODE_SW_SIM = 4'h5;
  localparam logic [3:0] MODE_SW_STST = 4'h6;
  localparam logic [3:0] MODE_TMR_START = 4'h7;
  localparam logic [3:0] MODE_LAST_LEGAL = 4'h8;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tpsr_bus_req_t;

  typedef struct packed {
    logic external_clock_in;
    logic external_trigger_in;
    logic measured_wave_in;
    logic stop_trigger_in;
  } tpsr_chan_in_t;

endpackage : tpsr_pkg

// ===== rtl/tpsr_sync2.sv
// Two-flop synchroniser for asynchronous pin levels
module tpsr_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // tpsr_sync2

// ===== verification/tpsr_core_model.sv
// Behavioural model of one base timer channel core seen from the routing block
module tpsr_core_model #(
  parameter int RUN = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Routed inputs and waveform
  input wire tpsr_pkg::tpsr_chan_in_t chan,
  output logic wave
);
  timeunit 1ns;
  timeprecision 1ps;
  logic trig_q;
  logic stop_q;
  logic [7:0] left;
  // Start on a trigger rise, stop on a stop fall; stop wins so a late fall is never lost
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trig_q <= 1'b0;
      stop_q <= 1'b0;
      left <= 8'h00;
    end else begin
      trig_q <= chan.external_trigger_in;
      stop_q <= chan.stop_trigger_in;
      if (stop_q && !chan.stop_trigger_in) begin
        left <= 8'h00;
      end else if (chan.external_trigger_in && !trig_q) begin
        left <= 8'(RUN);
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
    end
  end
  assign wave = (left != 8'h00);
endmodule // tpsr_core_model

// ===== verification/tpsr_pair_route_tb.sv
// Self-checking testbench for the timer pair start routing block
module tpsr_pair_route_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  tpsr_pkg::tpsr_bus_req_t bus_req = '0;
  logic [tpsr_pkg::DATA_W-1:0] bus_rdata;
  logic pin_e = 1'b0;
  logic pin_o = 1'b0;
  logic wave_e;
  logic wave_o;
  logic out_e;
  logic out_o;
  logic chain_i = 1'b1;
  logic chain_o;
  tpsr_pkg::tpsr_chan_in_t chan_e;
  tpsr_pkg::tpsr_chan_in_t chan_o;
  int fail_count = 0;
  int samples_checked = 0;

  // --------------------------------------------------------------
  // Clock, design and channel models
  // --------------------------------------------------------------
  always #2.5 core_clk = ~core_clk;
  tpsr_pair_route uut (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer_in_pin_even(pin_e), .timer_in_pin_odd(pin_o),
    .timer_out_pin_even(out_e), .timer_out_pin_odd(out_o),
    .channel_waveform_out_even(wave_e), .channel_waveform_out_odd(wave_o),
    .chan_even(chan_e), .chan_odd(chan_o), .chained_in(chain_i), .chained_out(chain_o));
  // Odd run is long so only a stop fall can end it early
  tpsr_core_model #(.RUN(6)) core_e (.core_clk(core_clk), .nrst(nrst), .chan(chan_e),
    .wave(wave_e));
  tpsr_core_model #(.RUN(20)) core_o (.core_clk(core_clk), .nrst(nrst), .chan(chan_o),
    .wave(wave_o));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(negedge core_clk);
    chk(bus_rdata, exp);
  endtask
  // Bounded wait on one model waveform, sampled mid-cycle
  task automatic wait_wave(input logic odd, input logic lvl);
    int n;
    n = 0;
    while ((odd ? wave_o : wave_e) !== lvl && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(n < 40), 32'h1);
  endtask
  task automatic conclude;
    $display("counts: %0d checked, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_regs;
    wr(tpsr_pkg::OFS_MODE, 32'h8);
    rd(tpsr_pkg::OFS_MODE, 32'h8);
    wr(tpsr_pkg::OFS_MODE, 32'h9);
    rd(tpsr_pkg::OFS_MODE, 32'h8);
    rd(tpsr_pkg::OFS_STATUS, 32'h4);
    wr(tpsr_pkg::OFS_STATUS, 32'h4);
    rd(tpsr_pkg::OFS_STATUS, 32'h0);
    rd(8'h0C, 32'h0);
    $display("test regs done");
  endtask
  task automatic test_mode5;
    wr(tpsr_pkg::OFS_MODE, 32'h5);
    pin_e <= 1'b1;
    pin_o <= 1'b1;
    repeat (5) @(negedge core_clk);
    chk({chan_e[3:1], chan_o}, 7'h01);
    wr(tpsr_pkg::OFS_START, 32'h3);
    @(negedge core_clk);
    chk({chan_e[3:1], chan_o[3:1]}, 6'h3F);
    @(negedge core_clk);
    chk({chan_e[3:1], chan_o[3:1]}, 6'h00);
    wait_wave(1'b0, 1'b1);
    @(negedge core_clk);
    chk({out_e, out_o, chain_o}, 3'h7);
    repeat (25) @(negedge core_clk);
    $display("test mode5 done");
  endtask
  task automatic test_mode6;
    wr(tpsr_pkg::OFS_MODE, 32'h6);
    wr(tpsr_pkg::OFS_START, 32'h2);
    repeat (2) @(negedge core_clk);
    chk({chan_e[3:1], chan_o, chain_o}, 8'h00);
    wr(tpsr_pkg::OFS_START, 32'h1);
    @(negedge core_clk);
    chk(chan_e[3:1], 3'h7);
    wait_wave(1'b0, 1'b1);
    @(negedge core_clk);
    chk({chan_o, chain_o}, 5'h1F);
    wait_wave(1'b1, 1'b1);
    wait_wave(1'b0, 1'b0);
    @(negedge core_clk);
    chk(chan_o, 4'h0);
    repeat (2) @(negedge core_clk);
    chk(wave_o, 1'b0);
    $display("test mode6 done");
  endtask
  task automatic test_mode7;
    @(posedge core_clk);
    pin_e <= 1'b0;
    pin_o <= 1'b0;
    wr(tpsr_pkg::OFS_MODE, 32'h7);
    repeat (5) @(negedge core_clk);
    chk({chan_e[3:1], chan_o}, 7'h01);
    @(posedge core_clk);
    pin_e <= 1'b1;
    pin_o <= 1'b1;
    // Two synchroniser flops and the routing stage: three edges from pin to channel
    repeat (3) @(negedge core_clk);
    chk(chan_e[3:1], 3'h0);
    @(negedge core_clk);
    chk({chan_e[3:1], chan_o}, 7'h71);
    wait_wave(1'b0, 1'b1);
    @(negedge core_clk);
    chk({chan_o, chain_o}, 5'h1F);
    wait_wave(1'b1, 1'b1);
    // No stop routing here, so the odd run outlives the even fall
    wait_wave(1'b0, 1'b0);
    repeat (2) @(negedge core_clk);
    chk(wave_o, 1'b1);
    $display("test mode7 done");
  endtask

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (11) @(posedge core_clk);
    @(negedge core_clk);
    chk(chan_o, 4'h0);
    @(posedge core_clk);
    nrst <= 1'b1;
    // Stop input only lifts on the first edge after release
    repeat (2) @(negedge core_clk);
    chk(chan_o[0], 1'b1);
    test_regs();
    test_mode5();
    test_mode6();
    test_mode7();
    conclude();
  end
  // Whole run takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule // tpsr_pair_route_tb
